// ---- core/spisd_pkg.sv ----
// Behaviour
// - transfer-done flag sets when each byte ends, master and slave.
// - transfer-done flag clears when the interrupt routine is vectored into.
// - software writing zero to transfer-done flag clears it.
// - data write while busy sets collision flag, byte dropped, shifter kept.
// - collision flag clears on write zero or data write when not busy.
// - mode fault setting clears serial enable and master select bits.
// - byte ending with buffer full keeps old buffer and sets overrun flag.
// - in master mode a data write loads shifter and starts a transfer.
// - reading the data register returns the receive buffer.
// - one eight-bit data address serves transmit and receive.
package spisd_pkg;
  localparam logic [7:0] ADDR_CONTROL = 8'hBC;
  localparam logic [7:0] ADDR_FLAGS   = 8'hBD;
  localparam logic [7:0] ADDR_DATA    = 8'hBE;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET    = 8'h00;
  // control bit positions
  localparam int CTL_ENABLE = 7;
  localparam int CTL_MASTER = 6;
  localparam int CTL_CPOL   = 5;
  localparam int CTL_CPHA   = 4;
  localparam int CTL_SELECT_PIN_DISABLE  = 3;
  localparam int CTL_LSBF   = 2;
  // flag bit positions
  localparam int FLG_DONE    = 7;
  localparam int FLG_WRITE_COLLISION_FLAG    = 6;
  localparam int FLG_MODE_FAULT_FLAG    = 5;
  localparam int FLG_OVERRUN = 4;
  localparam int FLG_FULL    = 3;
  localparam int FLG_BUSY    = 2;
  // sck edges per byte and half-period in clk cycles per rate code
  localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
  localparam logic [3:0] HALF_DIV2  = 4'h1;
  localparam logic [3:0] HALF_DIV4  = 4'h2;
  localparam logic [3:0] HALF_DIV8  = 4'h4;
  localparam logic [3:0] HALF_DIV16 = 4'h8;
  typedef enum logic {SPISD_IDLE, SPISD_SHIFT} spisd_state_t;
endpackage

// ---- core/spi_status_and_data.sv ----
`timescale 1ns/1ps
module spi_status_and_data
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWrite,
  input  wire logic       sfrRead,
  input  wire logic [7:0] sfrWdata,
  output logic      [7:0] sfrRdata,
  input  wire logic       isrVector,
  input  wire logic       linkClk,
  input  wire logic       ssIn_n,
  input  wire logic       mosiIn,
  input  wire logic       misoIn,
  output logic            sckOut,
  output logic            sckOe,
  output logic            mosiOut,
  output logic            mosiOe,
  output logic            misoOut,
  output logic            misoOe
);
  function automatic logic pickBit(input logic [7:0] b, input logic [2:0] n,
                                   input logic lsbFirst);
    pickBit = lsbFirst ? b[n] : b[3'h7 - n];
  endfunction

  function automatic logic [7:0] shiftIn(input logic [7:0] b, input logic d,
                                         input logic lsbFirst);
    shiftIn = lsbFirst ? {d, b[7:1]} : {b[6:0], d};
  endfunction

  logic [7:0] controlReg;
  logic       doneReg;
  logic       wcolReg;
  logic       modfReg;
  logic       overrunReg;
  logic       fullReg;
  logic [7:0] rxBufReg;
  logic [7:0] txHoldReg;
  spisd_pkg::spisd_state_t stateReg;
  logic [3:0] divCntReg;
  logic [4:0] edgeCntReg;
  logic [2:0] txIdxReg;
  logic [7:0] mRxReg;
  logic       mosiReg;
  logic       sckReg;
  logic       mDone;
  logic       sDone;
  logic       byteDone;
  logic [7:0] doneByte;
  logic       busy;
  logic       modfSet;
  logic [3:0] halfPeriod;
  logic       tick;
  logic       leading;
  logic       sampleNow;
  logic       shiftNow;

  logic       enable;
  logic       master;
  logic       cpol;
  logic       cpha;
  logic       select_pin_disable;
  logic       lsbf;
  assign enable = controlReg[spisd_pkg::CTL_ENABLE];
  assign master = controlReg[spisd_pkg::CTL_MASTER];
  assign cpol   = controlReg[spisd_pkg::CTL_CPOL];
  assign cpha   = controlReg[spisd_pkg::CTL_CPHA];
  assign select_pin_disable  = controlReg[spisd_pkg::CTL_SELECT_PIN_DISABLE];
  assign lsbf   = controlReg[spisd_pkg::CTL_LSBF];

  logic wrCtl;
  logic wrFlg;
  logic wrDat;
  logic rdDat;
  assign wrCtl = sfrWrite && sfrAddr == spisd_pkg::ADDR_CONTROL;
  assign wrFlg = sfrWrite && sfrAddr == spisd_pkg::ADDR_FLAGS;
  assign wrDat = sfrWrite && sfrAddr == spisd_pkg::ADDR_DATA;
  assign rdDat = sfrRead && sfrAddr == spisd_pkg::ADDR_DATA;

  // pin synchronisers
  logic [1:0] ssSync;
  logic [1:0] misoSync;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ssSync   <= 2'h3;
      misoSync <= 2'h0;
    end
    else
    begin
      ssSync   <= {ssSync[0], ssIn_n};
      misoSync <= {misoSync[0], misoIn};
    end
  end

  // slave link domain, held in reset while the select pin is high and select disable is clear
  logic       frameRst_n;
  logic [2:0] lCntReg;
  logic [7:0] lRxReg;
  logic [7:0] lByteReg;
  logic       lTogReg;
  logic [7:0] lNext;
  assign frameRst_n = reset_n && (select_pin_disable || !ssIn_n) && enable && !master;
  assign lNext = shiftIn(lRxReg, mosiIn, lsbf);

  always_ff @(posedge linkClk or negedge frameRst_n)
  begin
    if (!frameRst_n)
    begin
      lCntReg <= 3'h0;
      lRxReg  <= 8'h00;
    end
    else
    begin
      lCntReg <= lCntReg + 3'h1;
      lRxReg  <= lNext;
    end
  end

  // byte and toggle outlive the frame reset so no false event appears
  always_ff @(posedge linkClk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lByteReg <= 8'h00;
      lTogReg  <= 1'b0;
    end
    else if (frameRst_n && lCntReg == 3'h7)
    begin
      lByteReg <= lNext;
      lTogReg  <= !lTogReg;
    end
  end

  // toggle crossing; byte is stable for eight sck periods after it
  logic [2:0] togSync;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      togSync <= 3'h0;
    else
      togSync <= {togSync[1:0], lTogReg};
  end
  assign sDone = togSync[2] != togSync[1];

  // master clock generator and shifter
  always_comb
  begin
    case (controlReg[1:0])
      2'h0: halfPeriod = spisd_pkg::HALF_DIV2;
      2'h1: halfPeriod = spisd_pkg::HALF_DIV4;
      2'h2: halfPeriod = spisd_pkg::HALF_DIV8;
      default: halfPeriod = spisd_pkg::HALF_DIV16;
    endcase
  end
  assign tick      = stateReg == spisd_pkg::SPISD_SHIFT
                     && divCntReg == halfPeriod - 4'h1;
  assign leading   = !edgeCntReg[0];
  assign sampleNow = tick && (leading != cpha);
  assign shiftNow  = tick && (leading == cpha) && edgeCntReg != 5'h0;
  assign mDone     = tick && edgeCntReg == spisd_pkg::EDGES_PER_BYTE - 5'h1;
  assign modfSet   = enable && master && !select_pin_disable && !ssSync[1];

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stateReg   <= spisd_pkg::SPISD_IDLE;
      divCntReg  <= 4'h0;
      edgeCntReg <= 5'h0;
      txIdxReg   <= 3'h0;
      mRxReg     <= 8'h00;
      mosiReg    <= 1'b0;
      sckReg     <= 1'b0;
    end
    else
    begin
      case (stateReg)
        spisd_pkg::SPISD_IDLE:
        begin
          sckReg <= cpol;
          if (wrDat && !busy && enable && master && !modfSet)
          begin
            stateReg   <= spisd_pkg::SPISD_SHIFT;
            divCntReg  <= 4'h0;
            edgeCntReg <= 5'h0;
            // phase 0 puts the first bit out before the first edge
            txIdxReg   <= cpha ? 3'h0 : 3'h1;
            mosiReg    <= cpha ? mosiReg : pickBit(sfrWdata, 3'h0, lsbf);
          end
        end
        spisd_pkg::SPISD_SHIFT:
        begin
          divCntReg <= tick ? 4'h0 : divCntReg + 4'h1;
          if (tick)
          begin
            sckReg     <= !sckReg;
            edgeCntReg <= edgeCntReg + 5'h1;
          end
          if (sampleNow)
            mRxReg <= shiftIn(mRxReg, misoSync[1], lsbf);
          if ((shiftNow || (tick && cpha && edgeCntReg == 5'h0))
              && !(cpha == 1'b0 && edgeCntReg == 5'h0))
          begin
            mosiReg  <= pickBit(txHoldReg, txIdxReg, lsbf);
            txIdxReg <= txIdxReg + 3'h1;
          end
          // a fault aborts the byte, no completion is reported
          if (mDone || modfSet)
            stateReg <= spisd_pkg::SPISD_IDLE;
        end
        default: stateReg <= spisd_pkg::SPISD_IDLE;
      endcase
    end
  end

  // slave busy follows select pin or select disable bit, gated by enable bit
  assign busy = master ? stateReg == spisd_pkg::SPISD_SHIFT
                       : enable && (select_pin_disable || !ssSync[1]);
  assign byteDone = master ? mDone && !modfSet : sDone;
  // miso sync lags two clk; sampled value is one bit late at the fast rates
  // phase 0 took its last sample one edge before the end, phase 1 on it
  assign doneByte = !master ? lByteReg
                  : cpha ? shiftIn(mRxReg, misoSync[1], lsbf) : mRxReg;

  // control register; fault wins over a software write
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      controlReg <= spisd_pkg::CONTROL_RESET;
    else
    begin
      if (wrCtl)
        controlReg <= sfrWdata;
      if (modfSet)
      begin
        controlReg[spisd_pkg::CTL_ENABLE] <= 1'b0;
        controlReg[spisd_pkg::CTL_MASTER] <= 1'b0;
      end
    end
  end

  // transmit holding byte; dropped on collision
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      txHoldReg <= spisd_pkg::DATA_RESET;
    else if (wrDat && !busy)
      txHoldReg <= sfrWdata;
  end

  // status flags: hardware set beats software clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      doneReg    <= 1'b0;
      wcolReg    <= 1'b0;
      modfReg    <= 1'b0;
      overrunReg <= 1'b0;
      fullReg    <= 1'b0;
      rxBufReg   <= spisd_pkg::DATA_RESET;
    end
    else
    begin
      if (byteDone)
        doneReg <= 1'b1;
      else if (isrVector)
        doneReg <= 1'b0;
      else if (wrFlg && !sfrWdata[spisd_pkg::FLG_DONE])
        doneReg <= 1'b0;

      if (wrDat && busy)
        wcolReg <= 1'b1;
      else if (wrDat || (wrFlg && !sfrWdata[spisd_pkg::FLG_WRITE_COLLISION_FLAG]))
        wcolReg <= 1'b0;

      if (modfSet)
        modfReg <= 1'b1;
      else if (wrFlg && !sfrWdata[spisd_pkg::FLG_MODE_FAULT_FLAG])
        modfReg <= 1'b0;

      if (byteDone && fullReg)
        overrunReg <= 1'b1;
      else if (rdDat || (wrFlg && !sfrWdata[spisd_pkg::FLG_OVERRUN]))
        overrunReg <= 1'b0;

      if (byteDone)
        fullReg <= 1'b1;
      else if (rdDat || (wrFlg && !sfrWdata[spisd_pkg::FLG_FULL]))
        fullReg <= 1'b0;

      if (byteDone && !fullReg)
        rxBufReg <= doneByte;
    end
  end

  // read port, one cycle after the strobe
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sfrRdata <= 8'h00;
    else if (sfrRead)
    begin
      if (sfrAddr == spisd_pkg::ADDR_CONTROL)
        sfrRdata <= controlReg;
      else if (sfrAddr == spisd_pkg::ADDR_FLAGS)
        sfrRdata <= {doneReg, wcolReg, modfReg, overrunReg, fullReg,
                     busy, 2'h0};
      else if (sfrAddr == spisd_pkg::ADDR_DATA)
        sfrRdata <= rxBufReg;
      else
        sfrRdata <= 8'h00;
    end
  end

  assign sckOut  = sckReg;
  assign sckOe   = enable && master;
  assign mosiOut = mosiReg;
  assign mosiOe  = enable && master;
  // slave output bit chosen from the live link counter
  assign misoOut = pickBit(txHoldReg, lCntReg, lsbf);
  assign misoOe  = enable && !master && (select_pin_disable || !ssIn_n);
endmodule

// ---- tb/spisd_properties.sv ----
`timescale 1ns/1ps
module spisd_properties
(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic [7:0] sfrAddr,
  input wire logic       sfrWrite,
  input wire logic       sfrRead,
  input wire logic [7:0] sfrWdata,
  input wire logic [7:0] sfrRdata,
  input wire logic       ssIn_n,
  input wire logic       sckOe,
  input wire logic       mosiOe,
  input wire logic       misoOe
);
  logic selDis_reg;
  logic mapped;
  logic ctlWr;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  assign mapped = sfrAddr inside {8'hBC, 8'hBD, 8'hBE};
  assign ctlWr = sfrWrite && sfrAddr == 8'hBC;
  // shadow of select disable; a fault never clears it
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      selDis_reg <= 1'b0;
    else if (ctlWr)
      selDis_reg <= sfrWdata[3];
  chk_unmapped_zero:
    assert property (sfrRead && !mapped |=> sfrRdata == 8'h00)
      else $error("unmapped read not zero");
  chk_rdata_hold:
    assert property (!sfrRead |=> $stable(sfrRdata))
      else $error("read data moved");
  chk_spare_bits:
    assert property (sfrRead && sfrAddr == 8'hBD |=> sfrRdata[1:0] == 2'b00)
      else $error("spare flag bits set");
  chk_oe_pair:
    assert property (mosiOe == sckOe)
      else $error("mosi and sck enables differ");
  chk_one_driver:
    assert property (!(sckOe && misoOe))
      else $error("master and slave drive together");
  chk_fault_stop:
    assert property (sckOe && !ssIn_n && !selDis_reg |-> ##[1:8] !sckOe)
      else $error("mode fault left master on");
  chk_write_collision_flag_clear:
    assert property (sfrWrite && sfrAddr == 8'hBD && !sfrWdata[6] ##2
      sfrRead && sfrAddr == 8'hBD |=> !sfrRdata[6])
      else $error("collision flag not cleared");
  chk_master_start:
    assert property (ctlWr && sfrWdata[7:6] == 2'b11 && sfrWdata[3]
      |-> ##[1:2] sckOe)
      else $error("master enable not seen");
  cover property (sfrWrite && sfrAddr == 8'hBE && sckOe);
  cover property (misoOe);
  cover property ($fell(sckOe));
endmodule

bind spi_status_and_data spisd_properties u_spisd_properties
(
  .clk, .reset_n, .sfrAddr, .sfrWrite, .sfrRead, .sfrWdata, .sfrRdata,
  .ssIn_n, .sckOe, .mosiOe, .misoOe
);

// ---- tb/spisd_slave_model.sv ----
`timescale 1ns/1ps
module spisd_slave_model
(
  input wire logic       sck,
  input wire logic       mosi,
  input wire logic       load,
  input wire logic [7:0] txByte,
  output logic           miso,
  output logic     [7:0] rxByte
);
  logic [7:0] shift_reg;
  initial miso = 1'b0;
  always @(posedge load)
  begin
    shift_reg = txByte;
    miso = txByte[7];
  end
  // mode 0 only: sample on rise, shift on fall
  always @(posedge sck)
    rxByte = {rxByte[6:0], mosi};
  // past the last bit the line toggles, no stale hold
  always @(negedge sck)
  begin
    shift_reg = {shift_reg[6:0], ~shift_reg[0]};
    miso = shift_reg[7];
  end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] sfrAddr = 8'h00;
  logic       sfrWrite = 1'b0;
  logic       sfrRead = 1'b0;
  logic [7:0] sfrWdata = 8'h00;
  logic [7:0] sfrRdata;
  logic       isrVector = 1'b0;
  logic       linkClk = 1'b0;
  logic       ssIn_n = 1'b1;
  logic       mosiIn = 1'b0;
  logic       misoIn, sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe;
  logic       load = 1'b0;
  logic [7:0] txByte = 8'h00;
  logic [7:0] rxByte, v, t, s, got;
  int         error_cnt = 0;
  int         total_checks = 0;
  always #5 clk = ~clk;
  spi_status_and_data u_spi_status_and_data
  (
    .clk, .reset_n, .sfrAddr, .sfrWrite, .sfrRead, .sfrWdata, .sfrRdata,
    .isrVector, .linkClk, .ssIn_n, .mosiIn, .misoIn, .sckOut, .sckOe,
    .mosiOut, .mosiOe, .misoOut, .misoOe
  );
  spisd_slave_model u_spisd_slave_model
  (
    .sck(sckOut & sckOe), .mosi(mosiOut), .load, .txByte, .miso(misoIn),
    .rxByte
  );
  task check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h want %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfrAddr <= a;
    sfrWdata <= d;
    sfrWrite <= 1'b1;
    @(posedge clk);
    sfrWrite <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfrAddr <= a;
    sfrRead <= 1'b1;
    @(posedge clk);
    sfrRead <= 1'b0;
    #1 d = sfrRdata;
  endtask
  function automatic logic [7:0] flags(input logic [5:0] f);
    return {f, 2'b00};
  endfunction
  // master byte with a colliding second write while busy
  task xfer(input logic [7:0] tx, input logic [7:0] sx);
    txByte <= sx;
    load <= 1'b1;
    wr(8'hBE, tx);
    load <= 1'b0;
    rd(8'hBD, v);
    check(v & 8'h04, 8'h04);
    wr(8'hBE, ~tx);
    v = 8'h00;
    for (int i = 0; i < 200 && v[7] !== 1'b1; i++)
      rd(8'hBD, v);
    if (v[7] !== 1'b1)
    begin
      error_cnt++;
      results();
    end
    check(rxByte, tx);
  endtask
  initial
  begin
    void'($urandom(32'h5addc2f9));
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    rd(8'hBD, v);
    check(v, 8'h00);
    rd(8'hBE, v);
    check(v, 8'h00);
    rd(8'h55, v);
    check(v, 8'h00);
    wr(8'hBC, 8'hCA);
    t = 8'($urandom);
    s = 8'($urandom);
    xfer(t, s);
    check(v, flags(6'b110010));
    rd(8'hBE, v);
    check(v, s);
    wr(8'hBD, 8'h04);
    rd(8'hBD, v);
    check(v, 8'h00);
    xfer(8'hFF, 8'h00);
    @(posedge clk);
    isrVector <= 1'b1;
    @(posedge clk);
    isrVector <= 1'b0;
    rd(8'hBD, v);
    check(v, flags(6'b010010));
    xfer(8'($urandom), 8'($urandom));
    check(v, flags(6'b110110));
    rd(8'hBE, v);
    check(v, 8'h00);
    wr(8'hBD, 8'h00);
    wr(8'hBC, 8'hC2);
    ssIn_n <= 1'b0;
    repeat (8) @(posedge clk);
    rd(8'hBD, v);
    check(v & 8'h20, 8'h20);
    rd(8'hBC, v);
    check(v & 8'hC0, 8'h00);
    ssIn_n <= 1'b1;
    wr(8'hBD, 8'h00);
    wr(8'hBC, 8'h80);
    t = 8'($urandom);
    s = 8'($urandom);
    wr(8'hBE, t);
    ssIn_n <= 1'b0;
    repeat (4) @(posedge clk);
    // link clock only runs inside the frame, offset from clk
    #3;
    for (int i = 7; i >= 0; i--)
    begin
      mosiIn = s[i];
      #77 got[i] = misoOut;
      #3 linkClk = 1'b1;
      #80 linkClk = 1'b0;
    end
    mosiIn = ~mosiIn;
    repeat (8) @(posedge clk);
    ssIn_n <= 1'b1;
    rd(8'hBD, v);
    check(v & 8'h88, 8'h88);
    rd(8'hBE, v);
    check(v, s);
    check(got, t);
    results();
  end
endmodule
